// ---- hw/rts_params.svh ----
// Register map, field positions, command codes and timing for the sequencer.
`ifndef RTS_PARAMS_SVH
`define RTS_PARAMS_SVH
`define RTS_A_MODE 8'h00
`define RTS_A_OPCTL 8'h01
`define RTS_A_TXLO 8'h0B
`define RTS_A_TXHI 8'h0C
`define RTS_A_IRQ 8'h0D
`define RTS_A_GSET 8'h0E
`define RTS_A_CMD 8'h0F
`define RTS_A_RXDISP 8'h17
`define RTS_A_FSTAT 8'h1A
`define RTS_A_FDATA 8'h1B
`define RTS_A_COLL 8'h1C
`define RTS_B_NFC 0
`define RTS_B_AGC 1
`define RTS_B_TXEN 3
`define RTS_B_RXEN 6
`define RTS_B_EN 7
`define RTS_I_OSC 0
`define RTS_I_TX 1
`define RTS_I_RX 2
`define RTS_I_WL 3
`define RTS_I_ERR 4
`define RTS_I_COL 5
`define RTS_C_DEFAULT 8'hC1
`define RTS_C_CLEAR 8'hC2
`define RTS_C_TX_CRC 8'hC4
`define RTS_C_TX_NOCRC 8'hC5
`define RTS_C_CLR_RSSI 8'hD0
`define RTS_C_SQUELCH 8'hD1
`define RTS_RST_BYTE 8'h00
`define RTS_CLK_NS 10
`define RTS_BYTE_NS 75520
`define RTS_BYTE_CYC ((`RTS_BYTE_NS + `RTS_CLK_NS - 1) / `RTS_CLK_NS)
`endif

// ---- hw/rts_pkg.sv ----
// Types shared by the reader sequencer.
package rts_pkg;
  typedef enum logic [1:0] {
    RTS_IDLE = 2'b00,
    RTS_TX = 2'b01,
    RTS_RX = 2'b11
  } rts_state_t;
  typedef logic [7:0] rts_byte_t;
endpackage

// ---- hw/rts_sequencer.sv ----
// Reader transmit/receive sequencer with status display and FIFO.
//
// The strobed register port is this design's own decision.
`include "rts_params.svh"
module rts_sequencer #(
  parameter int FIFO_DEPTH = 32,
  parameter int TX_WL = 8,
  parameter int RX_WL = 24,
  parameter int BYTE_CYC = `RTS_BYTE_CYC
) (
  // Clock, reset and freeze.
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  // Host register port.
  input wire logic [7:0] i_addr,
  input wire rts_pkg::rts_byte_t i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output rts_pkg::rts_byte_t o_rd_data,
  output logic o_host_irq_line,
  // Pins and analog handshakes.
  input wire logic i_en_pin,
  input wire logic i_osc_ok,
  input wire logic i_target_det,
  output logic o_osc_run,
  output logic o_reg_en,
  // Transmit byte stream toward the modulator.
  output logic o_tx_valid,
  output rts_pkg::rts_byte_t o_tx_byte,
  output logic o_tx_crc,
  output logic o_tx_active,
  // Receive framing and measurement inputs; receive state, AGC and gain outputs.
  input wire logic i_rx_valid,
  input wire rts_pkg::rts_byte_t i_rx_byte,
  input wire logic i_rx_done,
  input wire logic i_rx_err,
  input wire logic i_rx_coll,
  input wire logic [7:0] i_coll_pos,
  input wire logic [3:0] i_rf_receive_input_one_lvl,
  input wire logic [2:0] i_agc_cut,
  output logic o_rx_active,
  output logic o_agc_run,
  output logic [2:0] o_gain_cut
);
  import rts_pkg::*;
  localparam int PW = $clog2(FIFO_DEPTH);

  // Pin inputs pass two flops; only the second stage is read.
  logic en_s1, en_s2, osc_s1, osc_s2, tgt_s1, tgt_s2;
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      {en_s1, en_s2, osc_s1, osc_s2, tgt_s1, tgt_s2} <= 6'h00;
    end else if (i_clk_en) begin
      {en_s1, osc_s1, tgt_s1} <= {i_en_pin, i_osc_ok, i_target_det};
      {en_s2, osc_s2, tgt_s2} <= {en_s1, osc_s1, tgt_s1};
    end
  end

  rts_state_t st_r, st_nxt;
  rts_byte_t mode_r, mode_nxt, opc_r, opc_nxt, txlo_r, txlo_nxt;
  rts_byte_t txhi_r, txhi_nxt, gset_r, gset_nxt, coll_r, coll_nxt;
  rts_byte_t rd_r, rd_nxt, txb_r, txb_nxt;
  logic [5:0] irq_r, irq_nxt, irq_set;
  logic [3:0] rssi_r, rssi_nxt;
  logic [2:0] sq_r, sq_nxt, agc_eff, gain;
  logic [15:0] rem_r, rem_nxt;
  logic [31:0] tick_r, tick_nxt;
  logic [PW:0] cnt_r, cnt_nxt;
  logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic osc_d_r, txv_r, txv_nxt, crc_r, crc_nxt;
  logic ready, full, empty, push, pop, wr_fd, rd_fd, cmd, tick;
  rts_byte_t push_d, disp;
  rts_byte_t mem [FIFO_DEPTH];

  // Larger of two gain reduction codes; every source only adds loss.
  function automatic logic [2:0] gmax(input logic [2:0] a, input logic [2:0] b);
    gmax = (a > b) ? a : b;
  endfunction

  // Ready comes from the enable bit or the synchronised pin.
  assign ready = opc_r[`RTS_B_EN] | en_s2;
  assign o_osc_run = ready;
  assign o_reg_en = ready;
  assign full = (cnt_r == (PW + 1)'(FIFO_DEPTH));
  assign empty = (cnt_r == '0);
  assign wr_fd = i_wr && (i_addr == `RTS_A_FDATA);
  assign rd_fd = i_rd && (i_addr == `RTS_A_FDATA);
  assign cmd = i_wr && (i_addr == `RTS_A_CMD);
  assign tick = (tick_r == 32'(BYTE_CYC - 1));

  // AGC counts only while listening, so the display is quiet otherwise.
  assign agc_eff = (st_r == RTS_RX && mode_r[`RTS_B_AGC]) ? i_agc_cut : 3'h0;
  assign gain = gmax(gmax(agc_eff, gset_r[2:0]), sq_r);
  assign disp = {rssi_r, mode_r[`RTS_B_NFC] ? tgt_s2 : osc_s2, gain};

  // FIFO port selection; receive data wins over a stray host write.
  always_comb begin
    push = 1'b0;
    pop = 1'b0;
    push_d = i_wr_data;
    if (st_r == RTS_RX && i_rx_valid && !full) begin
      push = 1'b1;
      push_d = i_rx_byte;
    end else if (wr_fd && !full) begin
      push = 1'b1;
    end
    if (st_r == RTS_TX) begin
      pop = tick && (rem_r != 16'h0000) && !empty;
    end else begin
      pop = rd_fd && !empty;
    end
  end

  // Sequencer, registers and flags.
  always_comb begin
    st_nxt = st_r;
    mode_nxt = mode_r;
    opc_nxt = opc_r;
    txlo_nxt = txlo_r;
    txhi_nxt = txhi_r;
    gset_nxt = gset_r;
    coll_nxt = coll_r;
    rssi_nxt = rssi_r;
    sq_nxt = sq_r;
    rem_nxt = rem_r;
    crc_nxt = crc_r;
    txv_nxt = 1'b0;
    txb_nxt = txb_r;
    tick_nxt = 32'h0;
    irq_set = 6'h00;
    wp_nxt = push ? wp_r + PW'(1) : wp_r;
    rp_nxt = pop ? rp_r + PW'(1) : rp_r;
    cnt_nxt = cnt_r + (PW + 1)'(push) - (PW + 1)'(pop);
    if (i_wr) begin
      case (i_addr)
        `RTS_A_MODE: mode_nxt = i_wr_data;
        `RTS_A_OPCTL: opc_nxt = i_wr_data;
        `RTS_A_TXLO: txlo_nxt = i_wr_data;
        `RTS_A_TXHI: txhi_nxt = i_wr_data;
        `RTS_A_GSET: gset_nxt = i_wr_data;
        default: ;
      endcase
    end
    // Oscillator came up while ready.
    if (ready && osc_s2 && !osc_d_r) begin
      irq_set[`RTS_I_OSC] = 1'b1;
    end
    case (st_r)
      RTS_TX: begin
        tick_nxt = tick ? 32'h0 : tick_r + 32'h1;
        if (pop) begin
          txv_nxt = 1'b1;
          txb_nxt = mem[rp_r];
          rem_nxt = rem_r - 16'h1;
        end
        if (rem_r == 16'h0000) begin
          irq_set[`RTS_I_TX] = 1'b1;
          st_nxt = RTS_RX;
        end
        if (cnt_r >= (PW + 1)'(TX_WL) && cnt_nxt < (PW + 1)'(TX_WL)
            && rem_nxt > 16'(cnt_nxt)) begin
          irq_set[`RTS_I_WL] = 1'b1;
        end
      end
      RTS_RX: begin
        if (i_rf_receive_input_one_lvl > rssi_r) begin
          rssi_nxt = i_rf_receive_input_one_lvl;
        end
        if (cnt_r <= (PW + 1)'(RX_WL) && cnt_nxt > (PW + 1)'(RX_WL)) begin
          irq_set[`RTS_I_WL] = 1'b1;
        end
        if (i_rx_err) begin
          irq_set[`RTS_I_ERR] = 1'b1;
        end
        if (i_rx_coll) begin
          irq_set[`RTS_I_COL] = 1'b1;
          coll_nxt = i_coll_pos;
        end
        if (i_rx_done) begin
          irq_set[`RTS_I_RX] = 1'b1;
          st_nxt = RTS_IDLE;
        end
      end
      default: ;
    endcase
    // Flags clear on read, but a new event in that cycle still lands.
    irq_nxt = ((i_rd && i_addr == `RTS_A_IRQ) ? 6'h00 : irq_r) | irq_set;
    if (cmd) begin
      case (i_wr_data)
        `RTS_C_CLEAR: {wp_nxt, rp_nxt, cnt_nxt} = '0;
        `RTS_C_TX_CRC, `RTS_C_TX_NOCRC: begin
          // Transmit is ignored unless ready with both enables set.
          if (st_r == RTS_IDLE && ready && opc_r[`RTS_B_TXEN]
              && opc_r[`RTS_B_RXEN]) begin
            st_nxt = RTS_TX;
            rem_nxt = {txhi_r, txlo_r};
            crc_nxt = (i_wr_data == `RTS_C_TX_CRC);
            sq_nxt = 3'h0;
          end
        end
        `RTS_C_CLR_RSSI: rssi_nxt = 4'h0;
        `RTS_C_SQUELCH: sq_nxt = (sq_r == 3'h7) ? sq_r : sq_r + 3'h1;
        `RTS_C_DEFAULT: begin
          st_nxt = RTS_IDLE;
          {mode_nxt, opc_nxt, txlo_nxt, txhi_nxt, gset_nxt, coll_nxt} = {6{`RTS_RST_BYTE}};
          {rssi_nxt, sq_nxt, rem_nxt, irq_nxt} = '0;
          {wp_nxt, rp_nxt, cnt_nxt} = '0;
        end
        default: ;
      endcase
    end
    // Read data for the next cycle.
    case (i_addr)
      `RTS_A_MODE: rd_nxt = mode_r;
      `RTS_A_OPCTL: rd_nxt = opc_r;
      `RTS_A_TXLO: rd_nxt = txlo_r;
      `RTS_A_TXHI: rd_nxt = txhi_r;
      `RTS_A_IRQ: rd_nxt = {2'h0, irq_r};
      `RTS_A_GSET: rd_nxt = gset_r;
      `RTS_A_RXDISP: rd_nxt = disp;
      `RTS_A_FSTAT: rd_nxt = 8'(cnt_r);
      `RTS_A_FDATA: rd_nxt = empty ? 8'h00 : mem[rp_r];
      `RTS_A_COLL: rd_nxt = coll_r;
      default: rd_nxt = 8'h00;
    endcase
    if (!i_rd) begin
      rd_nxt = 8'h00;
    end
  end

  // State registers; all of them hold while the clock enable is low.
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      st_r <= RTS_IDLE;
      {mode_r, opc_r, txlo_r, txhi_r, gset_r, coll_r, rd_r, txb_r} <= {8{`RTS_RST_BYTE}};
      {irq_r, rssi_r, sq_r, rem_r, tick_r} <= '0;
      {cnt_r, wp_r, rp_r, osc_d_r, txv_r, crc_r} <= '0;
    end else if (i_clk_en) begin
      st_r <= st_nxt;
      mode_r <= mode_nxt;
      opc_r <= opc_nxt;
      txlo_r <= txlo_nxt;
      txhi_r <= txhi_nxt;
      gset_r <= gset_nxt;
      coll_r <= coll_nxt;
      rd_r <= rd_nxt;
      txb_r <= txb_nxt;
      irq_r <= irq_nxt;
      rssi_r <= rssi_nxt;
      sq_r <= sq_nxt;
      rem_r <= rem_nxt;
      tick_r <= tick_nxt;
      cnt_r <= cnt_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      osc_d_r <= osc_s2;
      txv_r <= txv_nxt;
      crc_r <= crc_nxt;
    end
  end

  // FIFO storage has no reset; the count guards stale entries.
  always_ff @(posedge i_sys_clk) begin
    if (i_clk_en && push) begin
      mem[wp_r] <= push_d;
    end
  end

  assign o_rd_data = rd_r;
  assign o_host_irq_line = |irq_r;
  assign o_tx_valid = txv_r;
  assign o_tx_byte = txb_r;
  assign o_tx_crc = crc_r;
  assign o_tx_active = (st_r == RTS_TX);
  assign o_rx_active = (st_r == RTS_RX);
  assign o_agc_run = (st_r == RTS_RX) && mode_r[`RTS_B_AGC];
  assign o_gain_cut = gain;

  // Checks on the sequencer.
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  a_rssi_clear: assert property (i_clk_en && cmd && i_wr_data == `RTS_C_CLR_RSSI
      |=> rssi_r == 4'h0) else $error("rssi not cleared");
  a_disp_bit3: assert property (i_clk_en && i_rd && i_addr == `RTS_A_RXDISP
      |=> o_rd_data[3] == $past(mode_r[0] ? tgt_s2 : osc_s2))
      else $error("display bit 3 wrong");
  a_gain_floor: assert property (o_gain_cut >= gset_r[2:0] && o_gain_cut >= sq_r
      && o_gain_cut >= agc_eff) else $error("gain not combined");
  a_default_zero: assert property (i_clk_en && cmd && i_wr_data == `RTS_C_DEFAULT
      |=> {disp[7:4], disp[2:0]} == 7'h00) else $error("display not zero");
  a_ready_osc: assert property (ready |-> o_osc_run && o_reg_en)
      else $error("ready without oscillator");
  a_osc_irq: assert property (i_clk_en && ready && osc_s2 && !osc_d_r
      |=> irq_r[0] && o_host_irq_line) else $error("osc irq missing");
  a_tx_end: assert property (i_clk_en && st_r == RTS_TX && rem_r == 16'h0000
      |=> st_r == RTS_RX && irq_r[1] && o_rx_active) else $error("tx end");
  a_rx_done: assert property (i_clk_en && st_r == RTS_RX && i_rx_done
      |=> st_r == RTS_IDLE && irq_r[2]) else $error("rx end irq missing");
  a_rx_fault: assert property (i_clk_en && st_r == RTS_RX && (i_rx_err || i_rx_coll)
      |=> irq_r[4] || irq_r[5]) else $error("fault irq missing");
  a_water_tx: assert property (i_clk_en && st_r == RTS_TX && !$stable(cnt_r)
      && cnt_r == (PW + 1)'(TX_WL - 1) && $past(cnt_r) == (PW + 1)'(TX_WL)
      && rem_r > 16'(cnt_r) |-> irq_r[3]) else $error("tx water irq");
  a_fstat_read: assert property (i_clk_en && i_rd && i_addr == `RTS_A_FSTAT
      |=> o_rd_data == 8'($past(cnt_r))) else $error("fifo count read");

  c_tx_frame: cover property (st_r == RTS_TX ##[1:300] st_r == RTS_RX);
  c_rx_done: cover property (st_r == RTS_RX ##1 st_r == RTS_IDLE);
  c_water: cover property (irq_set[3]);
  c_collision: cover property (irq_set[5]);
endmodule // rts_sequencer

// ---- verification/rts_rf_model.sv ----
// Behavioural RF-side framer that answers every transmission with a short reply.
module rts_rf_model (
  // Clock and receiver state from the sequencer.
  input wire logic i_sys_clk,
  input wire logic i_rx_active,
  // Reply kind and reply bytes chosen by the bench.
  input wire logic i_kind,
  input wire logic [15:0] i_reply,
  // Framing outputs toward the sequencer.
  output logic o_rx_valid,
  output logic [7:0] o_rx_byte,
  output logic o_rx_done,
  output logic o_rx_err,
  output logic o_rx_coll,
  output logic [7:0] o_coll_pos,
  output logic [3:0] o_lvl
);
  timeunit 1ns;
  timeprecision 1ns;

  // A tag answers only after the receiver listens, and never before a guard time.
  initial begin
    o_rx_valid = 1'b0;
    o_rx_done = 1'b0;
    o_rx_err = 1'b0;
    o_rx_coll = 1'b0;
    o_rx_byte = 8'hA5;
    o_coll_pos = 8'h3C;
    o_lvl = 4'h0;
    forever begin
      @(posedge i_sys_clk iff i_rx_active === 1'b1);
      repeat (3) @(posedge i_sys_clk);
      if (i_kind == 1'b0) begin
        for (int i = 0; i < 2; i++) begin
          o_rx_valid <= 1'b1;
          o_rx_byte <= i_reply[8*i +: 8];
          o_lvl <= (i == 0) ? 4'h9 : 4'h5;
          @(posedge i_sys_clk);
        end
        // Released data shows the inverse so a stale sample cannot pass.
        o_rx_valid <= 1'b0;
        o_rx_byte <= ~i_reply[15:8];
      end else begin
        o_rx_coll <= 1'b1;
        o_coll_pos <= 8'h05;
        @(posedge i_sys_clk);
        o_rx_coll <= 1'b0;
        o_coll_pos <= 8'hFA;
        o_rx_err <= 1'b1;
        @(posedge i_sys_clk);
        o_rx_err <= 1'b0;
      end
      o_rx_done <= 1'b1;
      @(posedge i_sys_clk);
      o_rx_done <= 1'b0;
      wait (i_rx_active !== 1'b1);
    end
  end
endmodule // rts_rf_model

// ---- verification/tb_rts_sequencer.sv ----
// Self-checking bench for the reader sequencer with an RF-side partner.
`include "rts_params.svh"
module tb_rts_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk, i_reset_n, i_wr, i_rd, i_en_pin, i_osc_ok, i_target_det;
  logic [7:0] i_addr, i_wr_data, coll_pos, rx_byte, rd_data, tx_byte;
  logic [2:0] i_agc_cut, gain_cut;
  logic [3:0] lvl;
  logic rx_valid, rx_done, rx_err, rx_coll, irq, osc_run, tx_valid, tx_crc, tx_act, rx_act;
  logic agc_run, kind, rd_pend, clk_en, reg_en;
  logic [15:0] reply;
  logic [7:0] rd_q[$], tx_q[$];
  logic [31:0] xs;
  int failures, n_compared;

  rts_sequencer #(.BYTE_CYC(4)) i_rts_sequencer (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
    .i_clk_en(clk_en), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd),
    .o_rd_data(rd_data), .o_host_irq_line(irq), .i_en_pin(i_en_pin), .i_osc_ok(i_osc_ok),
    .i_target_det(i_target_det), .o_osc_run(osc_run), .o_reg_en(reg_en), .o_tx_valid(tx_valid),
    .o_tx_byte(tx_byte), .o_tx_crc(tx_crc), .o_tx_active(tx_act), .i_rx_valid(rx_valid),
    .i_rx_byte(rx_byte), .i_rx_done(rx_done), .i_rx_err(rx_err), .i_rx_coll(rx_coll),
    .i_coll_pos(coll_pos), .i_rf_receive_input_one_lvl(lvl), .i_agc_cut(i_agc_cut),
    .o_rx_active(rx_act), .o_agc_run(agc_run), .o_gain_cut(gain_cut));
  rts_rf_model i_rts_rf_model (.i_sys_clk(i_sys_clk), .i_rx_active(rx_act), .i_kind(kind),
    .i_reply(reply), .o_rx_valid(rx_valid), .o_rx_byte(rx_byte), .o_rx_done(rx_done),
    .o_rx_err(rx_err), .o_rx_coll(rx_coll), .o_coll_pos(coll_pos), .o_lvl(lvl));

  // Free-running 100 MHz clock.
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  // Fixed-seed xorshift keeps every run identical.
  function automatic logic [7:0] nxt();
    xs ^= xs << 13;
    xs ^= xs >> 17;
    xs ^= xs << 5;
    return xs[7:0];
  endfunction

  task automatic cmp(input string what, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // The strobe drops for one edge so back-to-back calls never reassign it in one step.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wr_data <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    @(posedge i_sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    @(posedge i_sys_clk);
  endtask

  // Bounded wait: 0 for the interrupt line, 1 for receive start, 2 for receive end.
  task automatic wt(input int c);
    int n;
    n = 0;
    while (n < 500 && !(c == 0 ? irq === 1'b1 : rx_act === (c == 1))) begin
      @(posedge i_sys_clk);
      n++;
    end
    if (n == 500) begin
      failures++;
      $display("[ERR] %0t wait %0d timed out", $time, c);
    end
  endtask

  task automatic stop_test();
    if (rd_q.size() != 0 || tx_q.size() != 0) failures++;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Watcher: read data stand one cycle after the strobe; sent bytes come in FIFO order.
  always @(posedge i_sys_clk) begin
    rd_pend <= i_rd;
    if (rd_pend === 1'b1) cmp("read", rd_data, rd_q.pop_front());
    if (tx_valid === 1'b1) cmp("tx byte", tx_byte, tx_q.pop_front());
  end

  // The whole sequence needs a few hundred cycles; this limit only cuts a hang.
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    failures++;
    stop_test();
  end

  // Main sequence: start-up, status display, frames, faults and set-default.
  initial begin
    xs = 32'h870A;
    {i_reset_n, i_wr, i_rd, i_en_pin, i_osc_ok, i_target_det, kind} = 7'h00;
    clk_en = 1'b1;
    i_addr = 8'h00;
    i_wr_data = 8'h00;
    i_agc_cut = 3'h0;
    reply = 16'h0000;
    repeat (12) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    @(posedge i_sys_clk);
    rd(`RTS_A_RXDISP, 8'h00);
    rd(8'h30, 8'h00);
    wr(`RTS_A_MODE, 8'h00);
    // Start-up commands and depth address are arbitrary codes the sequencer leaves alone.
    wr(`RTS_A_CMD, 8'hD6);
    wr(`RTS_A_CMD, 8'hD8);
    wr(8'h2A, 8'h40);
    wr(`RTS_A_CMD, 8'hD7);
    wr(`RTS_A_OPCTL, 8'hC8);
    cmp("osc run", {6'h00, reg_en, osc_run}, 8'h03);
    // A write while the clock enable is low must not land.
    clk_en <= 1'b0;
    wr(`RTS_A_OPCTL, 8'h00);
    clk_en <= 1'b1;
    rd(`RTS_A_OPCTL, 8'hC8);
    i_osc_ok <= 1'b1;
    wt(0);
    rd(`RTS_A_IRQ, 8'h01);
    rd(`RTS_A_RXDISP, 8'h08);
    wr(`RTS_A_MODE, 8'h01);
    rd(`RTS_A_RXDISP, 8'h00);
    i_target_det <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    rd(`RTS_A_RXDISP, 8'h08);
    wr(`RTS_A_MODE, 8'h00);
    wr(`RTS_A_CMD, `RTS_C_SQUELCH);
    rd(`RTS_A_RXDISP, 8'h09);
    wr(`RTS_A_GSET, 8'h03);
    rd(`RTS_A_RXDISP, 8'h0B);
    repeat (7) wr(`RTS_A_CMD, `RTS_C_SQUELCH);
    rd(`RTS_A_RXDISP, 8'h0F);
    // Short frame: clear, count, fill, send.
    reply = {nxt(), nxt()};
    wr(`RTS_A_CMD, `RTS_C_CLEAR);
    wr(`RTS_A_TXLO, 8'h03);
    wr(`RTS_A_TXHI, 8'h00);
    for (int i = 0; i < 3; i++) begin
      tx_q.push_back(nxt());
      wr(`RTS_A_FDATA, tx_q[i]);
    end
    wr(`RTS_A_CMD, `RTS_C_TX_NOCRC);
    wt(1);
    cmp("gain", {4'h0, tx_crc, gain_cut}, 8'h03);
    wt(2);
    rd(`RTS_A_IRQ, 8'h06);
    rd(`RTS_A_FSTAT, 8'h02);
    rd(`RTS_A_FDATA, reply[7:0]);
    rd(`RTS_A_FDATA, reply[15:8]);
    rd(`RTS_A_RXDISP, 8'h9B);
    wr(`RTS_A_CMD, `RTS_C_CLR_RSSI);
    rd(`RTS_A_RXDISP, 8'h0B);
    // Long frame: 20 bytes through a 12-byte start, refilled on the water interrupt.
    wr(`RTS_A_CMD, `RTS_C_CLEAR);
    wr(`RTS_A_TXLO, 8'h14);
    for (int i = 0; i < 20; i++) begin
      tx_q.push_back(nxt());
      if (i == 12) begin
        wr(`RTS_A_CMD, `RTS_C_TX_NOCRC);
        wt(0);
        cmp("tx active", {7'h00, tx_act}, 8'h01);
        rd(`RTS_A_IRQ, 8'h08);
      end
      wr(`RTS_A_FDATA, tx_q[tx_q.size() - 1]);
    end
    wt(1);
    wt(2);
    rd(`RTS_A_IRQ, 8'h06);
    // Faulty reply with automatic gain control running; the host then reads the position.
    kind <= 1'b1;
    i_agc_cut <= 3'h5;
    wr(`RTS_A_MODE, 8'h02);
    wr(`RTS_A_CMD, `RTS_C_CLEAR);
    wr(`RTS_A_TXLO, 8'h00);
    wr(`RTS_A_CMD, `RTS_C_TX_CRC);
    wt(1);
    cmp("agc", {3'h0, tx_crc, agc_run, gain_cut}, 8'h1D);
    wt(2);
    rd(`RTS_A_IRQ, 8'h36);
    rd(`RTS_A_COLL, 8'h05);
    rd(`RTS_A_RXDISP, 8'h9B);
    // Set-default with the oscillator dropped returns the display and controls to zero; the pin alone makes ready.
    i_osc_ok <= 1'b0;
    wr(`RTS_A_CMD, `RTS_C_DEFAULT);
    repeat (3) @(posedge i_sys_clk);
    rd(`RTS_A_RXDISP, 8'h00);
    rd(`RTS_A_OPCTL, 8'h00);
    i_en_pin <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    cmp("pin ready", {6'h00, reg_en, osc_run}, 8'h03);
    stop_test();
  end
endmodule // tb_rts_sequencer
